// [dv/cle_console_chk.sv]
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// console port checks
// ----------------------------------------
module cle_console_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic rx_break,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic mem_req,
  input wire cle_pkg::cle_mem_t mem_o,
  input wire logic mem_ack,
  input wire logic cmd_valid,
  input wire cle_pkg::cle_cmd_t cmd_o,
  input wire logic cmd_done,
  input wire logic halt_req
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  prompt_first_a: assert property (
    $rose(hresetn) |-> ##[1:3] tx_valid && tx_data == 8'h3E)
    else $error("no prompt after reset");
  // break may flush the queue, so it is excused
  tx_hold_a: assert property (
    tx_valid && !tx_ready && !rx_break |=> tx_valid && $stable(tx_data))
    else $error("tx byte dropped");
  mem_hold_a: assert property (
    mem_req && !mem_ack && !rx_break |=> mem_req && $stable(mem_o))
    else $error("memory request dropped");
  cmd_hold_a: assert property (
    cmd_valid && !cmd_done && !rx_break |=> cmd_valid && $stable(cmd_o))
    else $error("command changed while waiting");
  cmd_end_a: assert property (cmd_done |=> !cmd_valid)
    else $error("command still valid after done");
  cmd_quiet_a: assert property (cmd_valid |-> !rx_ready)
    else $error("input taken during command");
  mem_quiet_a: assert property (mem_req |-> !rx_ready)
    else $error("input taken during memory cycle");
  halt_cause_a: assert property (
    halt_req |-> $past(rx_break) || $past(rx_break, 2))
    else $error("halt without break");
  cover property (tx_valid && !tx_ready);
  cover property (mem_ack && mem_o.we);
  cover property (halt_req);
endmodule : cle_console_chk
bind cle_console cle_console_chk u_chk (.hclk, .hresetn, .rx_break,
  .rx_ready, .tx_valid, .tx_data, .tx_ready, .mem_req, .mem_o,
  .mem_ack, .cmd_valid, .cmd_o, .cmd_done, .halt_req);
`default_nettype wire

// [dv/cle_term.sv]
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// host terminal model
// ----------------------------------------
module cle_term (
  input wire logic clk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic [7:0] got [$];
  logic slow = 1'b0;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
  end
  // slow mode stalls every other cycle
  always @(posedge clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
  // byte held until taken or 3000 cycles pass; idle line shows its inverse
  task automatic put(input logic [7:0] b, output logic ok);
    int n = 0;
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_data <= b;
    do begin
      @(posedge clk);
      ok = rx_ready;
      n++;
    end while (!ok && n < 3000);
    rx_valid <= 1'b0;
    rx_data <= ~b;
  endtask : put
endmodule : cle_term
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// console bench
// ----------------------------------------
module tb;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic hreadyout, hresp, rx_valid, rx_ready, tx_valid, tx_ready;
  logic mem_req, cmd_valid, halt_req;
  logic rx_break = 1'b0, video = 1'b0, mem_ack = 1'b0, cmd_done = 1'b0;
  logic [7:0] rx_data, tx_data, mem_rdata = 8'h00;
  logic [7:0] mem [0:511];
  cle_pkg::cle_mem_t mem_o;
  cle_pkg::cle_cmd_t cmd_o;
  int bad_count = 0, comparisons = 0;
  always #50 hclk = ~hclk;
  // short second keeps the 10 s limit near 200 cycles
  cle_console #(.SEC_CYC(20)) dut (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout), .hwdata,
    .hrdata, .hreadyout, .hresp, .rx_valid, .rx_data, .rx_err(1'b0),
    .rx_break, .rx_ready, .tx_valid, .tx_data, .tx_ready,
    .video_mode(video), .mem_req, .mem_o, .mem_ack, .mem_err(1'b0),
    .mem_rdata, .cmd_valid, .cmd_o, .cmd_done, .cmd_err(1'b0),
    .halt_req);
  cle_term term (.clk(hclk), .rx_valid, .rx_data, .rx_ready,
    .tx_valid, .tx_data, .tx_ready);
  always @(posedge hclk) begin
    mem_ack <= mem_req && !mem_ack;
    if (mem_req && !mem_ack && mem_o.we)
      mem[mem_o.addr[8:0]] <= mem_o.wdata;
    mem_rdata <= mem_req ? mem[mem_o.addr[8:0]] : ~mem_rdata;
  end
  task automatic conclude();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude
  task automatic hang();
    bad_count++;
    $display("mismatch wait expected done seen timeout");
    conclude();
  endtask : hang
  task automatic chk8(input string s, input logic [7:0] e, g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : chk8
  task automatic chk32(input string s, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : chk32
  task automatic pull(output logic [7:0] b);
    int n;
    for (n = 0; n < 4000 && term.got.size() == 0; n++) @(posedge hclk);
    if (n == 4000) hang();
    b = term.got.pop_front();
  endtask : pull
  task automatic exp(input string s);
    logic [7:0] b;
    foreach (s[i]) begin
      pull(b);
      chk8("tx", s[i], b);
    end
  endtask : exp
  task automatic prompt();
    logic [7:0] b;
    int k = 0;
    for (int j = 0; j < 300 && k < 3; j++) begin
      pull(b);
      k = (b == 8'h3E) ? k + 1 : 0;
    end
    chk8("prompt", 8'h03, k[7:0]);
  endtask : prompt
  task automatic key(input logic [7:0] b);
    logic ok;
    term.put(b, ok);
    if (!ok) hang();
  endtask : key
  task automatic typ(input string s);
    foreach (s[i]) key(s[i]);
  endtask : typ
  function automatic logic [7:0] csum(input string s);
    logic [7:0] t = 8'h00;
    foreach (s[i]) t += s[i];
    return -t;
  endfunction : csum
  // mode 0 good sum, 1 wrong sum, 2 sum never sent
  task automatic xcmd(input string s, input logic [1:0] m);
    typ({s, "\r"});
    exp({s, "\r\n"});
    if (m < 2'h2) key(csum(s) + {7'h0, m[0]});
    exp(m == 2'h0 ? ">>>" : "?");
  endtask : xcmd
  task automatic ahb(input logic w, input logic [31:0] a, d,
                     output logic [31:0] r);
    int n;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    for (int p = 0; p < 2; p++) begin
      for (n = 0; n < 50; n++) begin
        @(posedge hclk);
        if (hreadyout === 1'b1) break;
      end
      if (n == 50) hang();
      r = hrdata;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
    end
  endtask : ahb
  task automatic brk(input logic [7:0] e);
    int n;
    @(posedge hclk);
    rx_break <= 1'b1;
    @(posedge hclk);
    rx_break <= 1'b0;
    for (n = 0; n < 20 && halt_req !== 1'b1; n++) @(negedge hclk);
    chk8("halt", e, {7'h0, n < 20});
  endtask : brk
  initial begin
    logic [31:0] r;
    int n;
    for (int i = 0; i < 512; i++) mem[i] = i[7:0] ^ 8'h5A;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    exp(">>>");
    typ("\r");
    exp("\r\n>>>");
    typ("AB\177\177C\025");
    exp("AB\\BA\\C^U\r");
    prompt();
    typ("\177A\022\007\003");
    exp("A\r\nA^G^C");
    prompt();
    typ("\017");
    exp("^O\r\n");
    typ("A\017B");
    exp("B");
    typ("\017\025");
    prompt();
    @(posedge hclk);
    video <= 1'b1;
    typ("A\177\003");
    exp("A\010 \010^C");
    prompt();
    video <= 1'b0;
    typ(" e  1f /q \r");
    exp(" e  1f /q \r\n");
    for (n = 0; n < 50 && cmd_valid !== 1'b1; n++) @(negedge hclk);
    chk8("key", 8'h45, cmd_o.key);
    chk32("arg", 32'h1F, cmd_o.arg0);
    chk8("nargs", 8'h01, {6'h0, cmd_o.nargs});
    @(posedge hclk);
    cmd_done <= 1'b1;
    @(posedge hclk);
    cmd_done <= 1'b0;
    prompt();
    repeat (81) typ("B");
    repeat (81) exp("B");
    typ("\r");
    exp("\r\n?");
    prompt();
    term.slow = 1'b1;
    xcmd("X 10 2", 2'h0);
    typ("\241\262\255");
    exp(">>>");
    chk8("mem", 8'hA1, mem[16]);
    chk8("mem", 8'hB2, mem[17]);
    xcmd("X 10 1", 2'h0);
    typ("\001\001");
    exp("?");
    prompt();
    xcmd("x 30 80000002", 2'h0);
    exp("jk+");
    prompt();
    term.slow = 1'b0;
    xcmd("X 10 1", 2'h1);
    prompt();
    xcmd("X 10 1", 2'h2);
    prompt();
    xcmd("X 10 2", 2'h0);
    typ("U");
    exp("?");
    prompt();
    ahb(1'b0, 32'h4, 32'h0, r);
    chk32("stat", 32'h1, r & 32'h1);
    ahb(1'b1, 32'h40, 32'hFFFFFFFF, r);
    ahb(1'b0, 32'h40, 32'h0, r);
    chk32("hole", 32'h0, r);
    typ("AB");
    exp("AB");
    brk(8'h00);
    prompt();
    ahb(1'b1, 32'h0, 32'h3, r);
    ahb(1'b0, 32'h4, 32'h0, r);
    chk32("stat", 32'h0, r & 32'h1);
    brk(8'h00);
    ahb(1'b1, 32'h0, 32'h2, r);
    brk(8'h01);
    prompt();
    conclude();
  end
endmodule : tb
`default_nettype wire

// [rtl/cle_cfg.svh]
`ifndef CLE_CFG_SVH
`define CLE_CFG_SVH
// Contract
// - prompt ">>>" when awaiting a command
// - CR ends line, echoes CR LF; empty reprompts
// - rubout echo: hard-copy backslashes, video erase
// - rubout on empty line ignored
// - kill line echoes ^U CR LF, reprompts
// - pause holds output until resume
// - discard toggle, echo ^O only going on
// - prompt, error, program mode cancel discard
// - retype sends CR LF then line
// - abort echoes ^C, clears line, pause, discard
// - break aborts silently or halts program
// - other controls echo caret form, stored
// - over 80 counted characters is error
// - command known from first letter
// - blanks collapse; qualifiers skipped
// - hex arguments, case ignored
// - count bit 31 picks unload
// - command checksum byte must sum to zero
// - load data plus checksum sum to zero
// - unload sends bytes, then negated sum
// - errors reported after whole transfer
// - byte gap 1 s, checksum within 10 s
`define CLE_REG_CTRL 8'h00
`define CLE_REG_STAT 8'h04
`define CLE_REG_XADR 8'h08
`define CLE_CTRL_HDIS 0
`define CLE_CTRL_RUN 1
`define CLE_LINE_MAX 80
`define CLE_SEC_NS 1000000000
`define CLE_CLK_NS 100
`define CLE_SEC_CYC (`CLE_SEC_NS / `CLE_CLK_NS)
`define CLE_GAP_S 4'h1
`define CLE_CSUM_S 4'hA
`define CLE_CR 8'h0D
`define CLE_LF 8'h0A
`define CLE_BS 8'h08
`define CLE_SP 8'h20
`define CLE_TAB 8'h09
`define CLE_DEL 8'h7F
`define CLE_K_U 8'h15
`define CLE_K_S 8'h13
`define CLE_K_Q 8'h11
`define CLE_K_O 8'h0F
`define CLE_K_R 8'h12
`define CLE_K_C 8'h03
`define CLE_GT 8'h3E
`define CLE_BSL 8'h5C
`define CLE_CARET 8'h5E
`define CLE_QM 8'h3F
`define CLE_BANG 8'h21
`define CLE_SLASH 8'h2F
`define CLE_KEY_X 8'h58
`endif

// [rtl/cle_console.sv]
// The AHB-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "cle_cfg.svh"
module cle_console #(
  parameter int SEC_CYC = `CLE_SEC_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_err,
  input wire logic rx_break,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic video_mode,
  output logic mem_req,
  output cle_pkg::cle_mem_t mem_o,
  input wire logic mem_ack,
  input wire logic mem_err,
  input wire logic [7:0] mem_rdata,
  output logic cmd_valid,
  output cle_pkg::cle_cmd_t cmd_o,
  input wire logic cmd_done,
  input wire logic cmd_err,
  output logic halt_req
);
  initial begin
    if (SEC_CYC < 2 || SEC_CYC > 16777215) begin
      $error("SEC_CYC out of range");
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic is_ctl(input logic [7:0] c);
    is_ctl = (c < 8'h20) || (c >= 8'h80 && c <= 8'h9F);
  endfunction : is_ctl
  function automatic logic [7:0] upc(input logic [7:0] c);
    upc = (c >= 8'h61 && c <= 8'h7A) ? c - 8'h20 : c;
  endfunction : upc
  function automatic logic [4:0] hexv(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) begin
      hexv = {1'b1, c[3:0]};
    end else if (c >= 8'h41 && c <= 8'h46) begin
      hexv = {1'b1, c[3:0] + 4'h9};
    end else begin
      hexv = 5'h00;
    end
  endfunction : hexv

  cle_pkg::cle_state_t st_r, st_nxt;
  logic [7:0] oq_r [0:5];
  logic [7:0] pb [0:5];
  logic [2:0] on_r, pn;
  logic [7:0] buf_r [0:`CLE_LINE_MAX];
  logic [7:0] cnt_r, sum_r, c, last;
  logic [6:0] ix_r, lim;
  logic rub_r, pause_r, disc_r, arm_r, hdis_r;
  logic vid_s1_r, vid_r;
  logic e_store, e_rub, e_ps, e_pc, e_arm, e_dc, e_dt, e_ix, e_mw;
  logic rx_take, pop, run_p;
  logic [23:0] div_r;
  logic [3:0] secs_r;
  logic [7:0] key_r, xsum_r;
  logic [1:0] tok_r, na_r;
  logic has_r, bad_r, hexok_r;
  logic [31:0] a0_r, a1_r, xadr_r;
  logic [30:0] xcnt_r;
  logic xerr_r, mreq_r, ul;
  cle_pkg::cle_ap_t ap_r;

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign run_p = ap_r.vld && ap_r.wr && ap_r.addr == `CLE_REG_CTRL
    && hwdata[`CLE_CTRL_RUN];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_r <= '0;
      hrdata <= 32'h0000_0000;
    end else if (hready) begin
      ap_r.vld <= hsel && htrans[1];
      ap_r.wr <= hwrite;
      ap_r.addr <= haddr[7:0];
      case (haddr[7:0])
        `CLE_REG_CTRL: hrdata <= {31'h0, hdis_r};
        `CLE_REG_STAT: hrdata <= {8'h00, key_r, cnt_r, 4'h0, xerr_r,
          disc_r, pause_r, st_r != cle_pkg::CLE_PROG};
        `CLE_REG_XADR: hrdata <= xadr_r;
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hdis_r <= 1'b0;
    end else if (ap_r.vld && ap_r.wr && ap_r.addr == `CLE_REG_CTRL) begin
      hdis_r <= hwdata[`CLE_CTRL_HDIS];
    end
  end

  // ----------------------------------------
  // pins and timebase
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vid_s1_r <= 1'b0;
      vid_r <= 1'b0;
    end else begin
      vid_s1_r <= video_mode;
      vid_r <= vid_s1_r;
    end
  end

  // restarting on each byte makes the gap limit exact, not +-1 s
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r <= 24'h000000;
      secs_r <= 4'h0;
    end else if (rx_take || st_r != st_nxt) begin
      div_r <= 24'h000000;
      secs_r <= 4'h0;
    end else if (div_r == 24'(SEC_CYC - 1)) begin
      div_r <= 24'h000000;
      if (secs_r != 4'hF) begin
        secs_r <= secs_r + 4'h1;
      end
    end else begin
      div_r <= div_r + 24'h000001;
    end
  end

  // ----------------------------------------
  // output queue
  // ----------------------------------------
  assign tx_valid = on_r != 3'd0 && !disc_r && !pause_r;
  assign tx_data = oq_r[0];
  assign pop = on_r != 3'd0 && (disc_r || (tx_ready && !pause_r));
  assign rx_ready = on_r == 3'd0 && !mreq_r && (st_r == cle_pkg::CLE_EDIT
    || st_r == cle_pkg::CLE_XCS || st_r == cle_pkg::CLE_XLD
    || st_r == cle_pkg::CLE_XLCS || st_r == cle_pkg::CLE_XUL);
  assign rx_take = rx_valid && rx_ready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      on_r <= 3'd0;
      for (int i = 0; i < 6; i++) begin
        oq_r[i] <= 8'h00;
      end
    end else if (rx_break) begin
      on_r <= 3'd0;
    end else if (pn != 3'd0) begin
      on_r <= pn;
      for (int i = 0; i < 6; i++) begin
        oq_r[i] <= pb[i];
      end
    end else if (pop) begin
      on_r <= on_r - 3'd1;
      for (int i = 0; i < 5; i++) begin
        oq_r[i] <= oq_r[i + 1];
      end
    end
  end

  // ----------------------------------------
  // control machine
  // ----------------------------------------
  assign c = rx_data;
  assign last = buf_r[cnt_r > 8'd81 ? 7'd80 : 7'(cnt_r - 8'd1)];
  assign lim = cnt_r > 8'd81 ? 7'd81 : cnt_r[6:0];
  assign ul = st_r == cle_pkg::CLE_EDIT || st_r == cle_pkg::CLE_XUL;

  always_comb begin
    st_nxt = st_r;
    pn = 3'd0;
    for (int i = 0; i < 6; i++) begin
      pb[i] = 8'h00;
    end
    {e_store, e_rub, e_ps, e_pc, e_arm, e_dc, e_dt, e_ix, e_mw} = '0;
    if (rx_break) begin
      if (st_r != cle_pkg::CLE_PROG) begin
        st_nxt = cle_pkg::CLE_PRMT;
        e_pc = 1'b1;
        e_dc = 1'b1;
      end else if (!hdis_r) begin
        st_nxt = cle_pkg::CLE_PRMT;
      end
    end else if (run_p && st_r != cle_pkg::CLE_PROG) begin
      st_nxt = cle_pkg::CLE_PROG;
      e_dc = 1'b1;
      e_pc = 1'b1;
    end else if (rx_take && ul && (c == `CLE_K_S || c == `CLE_K_Q
        || c == `CLE_K_O || c == `CLE_K_C)) begin
      case (c)
        `CLE_K_S: e_ps = 1'b1;
        `CLE_K_Q: e_pc = 1'b1;
        `CLE_K_O: begin
          e_pc = 1'b1;
          if (disc_r) begin
            e_dc = 1'b1;
          end else begin
            pb[0] = `CLE_CARET;
            pb[1] = 8'h4F;
            pb[2] = `CLE_CR;
            pb[3] = `CLE_LF;
            pn = 3'd4;
            e_arm = 1'b1;
          end
        end
        default: begin
          pb[0] = `CLE_CARET;
          pb[1] = 8'h43;
          pb[2] = `CLE_CR;
          pb[3] = `CLE_LF;
          pn = 3'd4;
          e_pc = 1'b1;
          e_dc = 1'b1;
          st_nxt = cle_pkg::CLE_PRMT;
        end
      endcase
    end else begin
      case (st_r)
        cle_pkg::CLE_PRMT, cle_pkg::CLE_ERR: begin
          e_dc = 1'b1;
          if (on_r == 3'd0 && !disc_r) begin
            pb[0] = st_r == cle_pkg::CLE_ERR ? `CLE_QM : `CLE_GT;
            pb[1] = st_r == cle_pkg::CLE_ERR ? `CLE_CR : `CLE_GT;
            pb[2] = st_r == cle_pkg::CLE_ERR ? `CLE_LF : `CLE_GT;
            pn = 3'd3;
            st_nxt = st_r == cle_pkg::CLE_ERR ? cle_pkg::CLE_PRMT
              : cle_pkg::CLE_EDIT;
          end
        end
        cle_pkg::CLE_EDIT: begin
          if (rx_take) begin
            case (c)
              `CLE_CR: begin
                pb[0] = `CLE_CR;
                pb[1] = `CLE_LF;
                pn = 3'd2;
                st_nxt = cnt_r > 8'(`CLE_LINE_MAX) ? cle_pkg::CLE_ERR
                  : cle_pkg::CLE_PARS;
              end
              `CLE_DEL: begin
                if (cnt_r != 8'd0) begin
                  e_rub = 1'b1;
                  if (vid_r) begin
                    pb[0] = `CLE_BS;
                    pb[1] = `CLE_SP;
                    pb[2] = `CLE_BS;
                    pb[3] = `CLE_BS;
                    pb[4] = `CLE_SP;
                    pb[5] = `CLE_BS;
                    pn = is_ctl(last) ? 3'd6 : 3'd3;
                  end else begin
                    pn = rub_r ? 3'd0 : 3'd1;
                    pb[0] = `CLE_BSL;
                    pb[pn] = is_ctl(last) ? `CLE_CARET : last;
                    pb[pn + 3'd1] = last + 8'h40;
                    pn = pn + (is_ctl(last) ? 3'd2 : 3'd1);
                  end
                end
              end
              `CLE_K_U: begin
                pb[0] = `CLE_CARET;
                pb[1] = 8'h55;
                pb[2] = `CLE_CR;
                pb[3] = `CLE_LF;
                pn = 3'd4;
                st_nxt = cle_pkg::CLE_PRMT;
              end
              `CLE_K_R: begin
                pb[0] = `CLE_CR;
                pb[1] = `CLE_LF;
                pn = 3'd2;
                st_nxt = cle_pkg::CLE_RTYP;
              end
              default: begin
                e_store = 1'b1;
                pn = rub_r ? 3'd1 : 3'd0;
                pb[0] = `CLE_BSL;
                pb[pn] = is_ctl(c) ? `CLE_CARET : c;
                pb[pn + 3'd1] = c + 8'h40;
                pn = pn + (is_ctl(c) ? 3'd2 : 3'd1);
              end
            endcase
          end
        end
        cle_pkg::CLE_RTYP: begin
          if (on_r == 3'd0) begin
            if (ix_r < lim) begin
              e_ix = 1'b1;
              pb[0] = is_ctl(buf_r[ix_r]) ? `CLE_CARET : buf_r[ix_r];
              pb[1] = buf_r[ix_r] + 8'h40;
              pn = is_ctl(buf_r[ix_r]) ? 3'd2 : 3'd1;
            end else begin
              st_nxt = cle_pkg::CLE_EDIT;
            end
          end
        end
        cle_pkg::CLE_PARS: begin
          if (ix_r != cnt_r[6:0]) begin
            e_ix = 1'b1;
          end else if (!has_r || key_r == `CLE_BANG) begin
            st_nxt = cle_pkg::CLE_PRMT;
          end else if (bad_r) begin
            st_nxt = cle_pkg::CLE_ERR;
          end else if (key_r == `CLE_KEY_X) begin
            st_nxt = na_r == 2'd2 && hexok_r ? cle_pkg::CLE_XCS
              : cle_pkg::CLE_ERR;
          end else begin
            st_nxt = cle_pkg::CLE_CMD;
          end
        end
        cle_pkg::CLE_CMD: begin
          if (cmd_done) begin
            st_nxt = cmd_err ? cle_pkg::CLE_ERR : cle_pkg::CLE_PRMT;
          end
        end
        cle_pkg::CLE_XCS: begin
          if (rx_take) begin
            if (sum_r + c == 8'h00) begin
              pb[0] = `CLE_GT;
              pb[1] = `CLE_GT;
              pb[2] = `CLE_GT;
              pn = 3'd3;
              e_dc = 1'b1;
              st_nxt = a1_r[31] ? cle_pkg::CLE_XUL
                : xcnt_r == 31'd0 ? cle_pkg::CLE_XLCS : cle_pkg::CLE_XLD;
            end else begin
              st_nxt = cle_pkg::CLE_ERR;
            end
          end else if (secs_r >= `CLE_CSUM_S) begin
            st_nxt = cle_pkg::CLE_ERR;
          end
        end
        cle_pkg::CLE_XLD: begin
          if (rx_take) begin
            e_mw = 1'b1;
            if (xcnt_r == 31'd1) begin
              st_nxt = cle_pkg::CLE_XLCS;
            end
          end else if (secs_r >= `CLE_GAP_S) begin
            st_nxt = cle_pkg::CLE_ERR;
          end
        end
        cle_pkg::CLE_XLCS: begin
          if (rx_take) begin
            st_nxt = xsum_r + c == 8'h00 && !xerr_r && !rx_err
              ? cle_pkg::CLE_PRMT : cle_pkg::CLE_ERR;
          end else if (secs_r >= `CLE_CSUM_S) begin
            st_nxt = cle_pkg::CLE_ERR;
          end
        end
        cle_pkg::CLE_XUL: begin
          if (mreq_r && mem_ack) begin
            pb[0] = mem_rdata;
            pn = 3'd1;
          end else if (xcnt_r == 31'd0 && !mreq_r && on_r == 3'd0) begin
            pb[0] = 8'h00 - xsum_r;
            pn = 3'd1;
            st_nxt = xerr_r ? cle_pkg::CLE_ERR : cle_pkg::CLE_PRMT;
          end
        end
        default: st_nxt = st_r;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= cle_pkg::CLE_PRMT;
      halt_req <= 1'b0;
    end else begin
      st_r <= st_nxt;
      halt_req <= rx_break && st_r == cle_pkg::CLE_PROG && !hdis_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pause_r <= 1'b0;
      disc_r <= 1'b0;
      arm_r <= 1'b0;
    end else begin
      if (e_pc) begin
        pause_r <= 1'b0;
      end else if (e_ps) begin
        pause_r <= 1'b1;
      end
      // arm waits for the ^O echo to leave before discarding
      if (e_dc) begin
        disc_r <= 1'b0;
        arm_r <= 1'b0;
      end else if (e_arm) begin
        arm_r <= 1'b1;
      end else if (arm_r && on_r == 3'd0) begin
        disc_r <= 1'b1;
        arm_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // line buffer and length count
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 8'd0;
      sum_r <= 8'h00;
      rub_r <= 1'b0;
      for (int i = 0; i <= `CLE_LINE_MAX; i++) begin
        buf_r[i] <= 8'h00;
      end
    end else if (st_r == cle_pkg::CLE_PRMT || rx_break) begin
      cnt_r <= 8'd0;
      sum_r <= 8'h00;
      rub_r <= 1'b0;
    end else if (e_store) begin
      if (cnt_r <= 8'(`CLE_LINE_MAX)) begin
        buf_r[cnt_r[6:0]] <= c;
      end
      if (cnt_r != 8'hFF) begin
        cnt_r <= cnt_r + 8'd1;
      end
      sum_r <= sum_r + c;
      rub_r <= 1'b0;
    end else if (e_rub) begin
      cnt_r <= cnt_r - 8'd1;
      sum_r <= sum_r - last;
      rub_r <= !vid_r;
    end
  end

  // ----------------------------------------
  // parser
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    logic [7:0] u;
    logic [4:0] h;
    if (!hresetn) begin
      ix_r <= 7'd0;
      {key_r, tok_r, na_r, has_r, bad_r, hexok_r} <= '0;
      a0_r <= 32'h0000_0000;
      a1_r <= 32'h0000_0000;
    end else if (st_r != st_nxt) begin
      ix_r <= 7'd0;
      if (st_nxt == cle_pkg::CLE_PARS) begin
        {key_r, tok_r, na_r, has_r, bad_r} <= '0;
        hexok_r <= 1'b1;
        a0_r <= 32'h0000_0000;
        a1_r <= 32'h0000_0000;
      end
    end else if (e_ix) begin
      ix_r <= ix_r + 7'd1;
      u = upc(buf_r[ix_r]);
      h = hexv(u);
      if (st_r != cle_pkg::CLE_PARS || key_r == `CLE_BANG) begin
        bad_r <= bad_r;
      end else if (is_ctl(u)) begin
        bad_r <= 1'b1;
      end else if (u == `CLE_SP || u == `CLE_TAB) begin
        tok_r <= 2'd0;
      end else if (!has_r) begin
        key_r <= u;
        has_r <= 1'b1;
        tok_r <= 2'd1;
      end else if (u == `CLE_SLASH) begin
        tok_r <= 2'd3;
      end else if (tok_r == 2'd0) begin
        tok_r <= 2'd2;
        na_r <= na_r == 2'd3 ? 2'd3 : na_r + 2'd1;
        hexok_r <= hexok_r && h[4];
        if (na_r == 2'd0) begin
          a0_r <= {28'h0, h[3:0]};
        end else if (na_r == 2'd1) begin
          a1_r <= {28'h0, h[3:0]};
        end
      end else if (tok_r == 2'd2) begin
        hexok_r <= hexok_r && h[4];
        if (na_r == 2'd1) begin
          a0_r <= {a0_r[27:0], h[3:0]};
        end else if (na_r == 2'd2) begin
          a1_r <= {a1_r[27:0], h[3:0]};
        end
      end
    end
  end

  assign cmd_valid = st_r == cle_pkg::CLE_CMD;
  assign cmd_o = '{key: key_r, arg0: a0_r, arg1: a1_r, nargs: na_r,
    hex_ok: hexok_r};

  // ----------------------------------------
  // binary transfer and memory port
  // ----------------------------------------
  assign mem_req = mreq_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mreq_r <= 1'b0;
      mem_o <= '0;
      xadr_r <= 32'h0000_0000;
      xcnt_r <= 31'd0;
      xsum_r <= 8'h00;
      xerr_r <= 1'b0;
    end else if (st_r == cle_pkg::CLE_PARS) begin
      xadr_r <= a0_r;
      xcnt_r <= a1_r[30:0];
      xsum_r <= 8'h00;
      xerr_r <= 1'b0;
    end else if (mreq_r) begin
      if (mem_ack) begin
        mreq_r <= 1'b0;
        xadr_r <= xadr_r + 32'h0000_0001;
        xerr_r <= xerr_r || mem_err;
        if (!mem_o.we) begin
          xsum_r <= xsum_r + mem_rdata;
          xcnt_r <= xcnt_r - 31'd1;
        end
      end
    end else if (e_mw) begin
      mreq_r <= 1'b1;
      mem_o <= '{we: 1'b1, addr: xadr_r, wdata: c};
      xsum_r <= xsum_r + c;
      xcnt_r <= xcnt_r - 31'd1;
      xerr_r <= xerr_r || rx_err;
    end else if (st_r == cle_pkg::CLE_XUL && st_nxt == st_r
        && on_r == 3'd0 && xcnt_r != 31'd0 && !rx_take) begin
      mreq_r <= 1'b1;
      mem_o <= '{we: 1'b0, addr: xadr_r, wdata: 8'h00};
    end
  end
endmodule : cle_console
`default_nettype wire

// [rtl/cle_pkg.sv]
package cle_pkg;
  typedef enum logic [10:0] {
    CLE_PROG = 11'h001,
    CLE_PRMT = 11'h002,
    CLE_EDIT = 11'h004,
    CLE_RTYP = 11'h008,
    CLE_PARS = 11'h010,
    CLE_CMD = 11'h020,
    CLE_XCS = 11'h040,
    CLE_XLD = 11'h080,
    CLE_XLCS = 11'h100,
    CLE_XUL = 11'h200,
    CLE_ERR = 11'h400
  } cle_state_t;
  typedef struct packed {
    logic [7:0] key;
    logic [31:0] arg0;
    logic [31:0] arg1;
    logic [1:0] nargs;
    logic hex_ok;
  } cle_cmd_t;
  typedef struct packed {
    logic we;
    logic [31:0] addr;
    logic [7:0] wdata;
  } cle_mem_t;
  typedef struct packed {
    logic vld;
    logic wr;
    logic [7:0] addr;
  } cle_ap_t;
endpackage : cle_pkg
